// File: rtl/asrc_readout.v
/*
 Digital control and serial readout of a 16-bit differential converter.
 Assumes one clock pclk, asynchronous active-low presetn, an APB master,
 and a burst shift clock from the host much slower than pclk.
*/
`timescale 1ns/1ps
`include "asrc_regs.vh"

// What this block does
// [R1] Host never drives both selects low
// [R2] Select 01: buffer on, reference off
// [R3] Select 10: reference and buffer both off
// [R4] Select 11: reference and buffer on
// [R5] Start rising edge samples, begins conversion
// [R6] Negative start leg grounded means CMOS input
// [R7] Result leaves serially on data output
// [R8] Grounded echo pin selects self-clocked mode
// [R9] Self-clocked mode sends header 10 first
// [R10] Echoed mode copies shift clock out
// [R11] Echoed mode changes data on falling edge
// [R12] Data advances on shift clock falling edge
// [R13] Host restarts within 10000 ns
// [R14] Host clocks 16 or 18 bits
// [R15] Shift clock bursts, idles low
// [R16] Result goes out MSB first
module asrc_readout (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        convert_start_pos,
  input  wire        convert_start_neg,
  input  wire        shift_clk_pos,
  input  wire        echo_clock_strap,
  input  wire [15:0] analog_code,
  output reg         serial_data_out,
  output reg         echo_clock_out,
  output reg         ref_select_low,
  output reg         ref_select_high,
  output reg         buffer_enable,
  output reg         reference_enable,
  output reg         sample_hold,
  output reg         convert_done
);

  localparam ST_IDLE  = 2'd0;
  localparam ST_SHIFT = 2'd1;

  // Header as a sized constant so its bits can be picked singly
  localparam [1:0] HDR = `ASRC_HEADER;

  // Three-stage synchronisers for pins
  reg [2:0]  cnv_p_s_r;
  reg [2:0]  cnv_n_s_r;
  reg [2:0]  sclk_s_r;
  reg [2:0]  strap_s_r;
  reg        cnv_lvl_r;
  reg        sclk_lvl_r;
  reg        strap_lvl_r;
  reg        cmos_r;

  reg [31:0] ctrl_r;
  reg [1:0]  state_r;
  reg [17:0] shreg_r;
  reg [4:0]  left_r;
  reg [15:0] result_r;
  reg [15:0] cnt_r;
  reg        stale_r;
  reg [13:0] gap_r;
  reg        gap_seen_r;
  reg        self_r;

  // Next values of the shift path
  reg [1:0]  state_nxt;
  reg [17:0] shreg_nxt;
  reg [4:0]  left_nxt;
  reg        data_nxt;

  // Agreement of last two stages marks a settled level
  function agree;
    input [2:0] s;
    begin
      agree = s[2] ~^ s[1];
    end
  endfunction

  wire cnv_raw    = cmos_r ? cnv_p_s_r[2] :
                    (cnv_p_s_r[2] & ~cnv_n_s_r[2]);
  wire cnv_ok     = cmos_r ? agree(cnv_p_s_r) :
                    (agree(cnv_p_s_r) & agree(cnv_n_s_r));
  wire cnv_rise   = cnv_ok & cnv_raw & ~cnv_lvl_r;
  wire sclk_ok    = agree(sclk_s_r);
  wire sclk_fall  = sclk_ok & ~sclk_s_r[2] & sclk_lvl_r;
  wire apb_wr     = psel & penable & pwrite & pready;
  wire apb_setup  = psel & ~penable;
  wire [1:0] sel  = {ctrl_r[`ASRC_CTRL_SEL_HI], ctrl_r[`ASRC_CTRL_SEL_LO]};

  // Echo follows the settled clock level in the same cycle as the
  // data shift, so data never moves a cycle ahead of the echo edge
  wire echo_nxt   = strap_lvl_r & (sclk_ok ? sclk_s_r[2] : sclk_lvl_r);

  // Gap counter saturates, so a long idle cannot wrap to look short
  wire gap_full   = (gap_r == `ASRC_MAX_GAP_CYC);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnv_p_s_r   <= 3'b000;
      cnv_n_s_r   <= 3'b000;
      sclk_s_r    <= 3'b000;
      strap_s_r   <= 3'b000;
      cnv_lvl_r   <= 1'b0;
      sclk_lvl_r  <= 1'b0;
      strap_lvl_r <= 1'b0;
      cmos_r      <= 1'b1;
    end else begin
      cnv_p_s_r <= {cnv_p_s_r[1:0], convert_start_pos};
      cnv_n_s_r <= {cnv_n_s_r[1:0], convert_start_neg};
      sclk_s_r  <= {sclk_s_r[1:0], shift_clk_pos};
      strap_s_r <= {strap_s_r[1:0], echo_clock_strap};
      if (cnv_ok)
        cnv_lvl_r <= cnv_raw;
      if (sclk_ok)
        sclk_lvl_r <= sclk_s_r[2];
      if (agree(strap_s_r))
        strap_lvl_r <= strap_s_r[2];
      // Negative leg held low while idle means CMOS drive
      if (agree(cnv_n_s_r) && !cnv_lvl_r)
        cmos_r <= ~cnv_n_s_r[2]; // [R6]
    end
  end

  // Reference scheme decode; illegal pair turns everything off
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_select_low   <= 1'b1;
      ref_select_high  <= 1'b1;
      buffer_enable    <= 1'b0;
      reference_enable <= 1'b0;
    end else begin
      ref_select_low  <= sel[0];
      ref_select_high <= sel[1];
      case (sel)
        2'b01: begin
          buffer_enable    <= 1'b1; // [R2]
          reference_enable <= 1'b0;
        end
        2'b10: begin
          buffer_enable    <= 1'b0; // [R3]
          reference_enable <= 1'b0;
        end
        2'b11: begin
          buffer_enable    <= 1'b1; // [R4]
          reference_enable <= 1'b1;
        end
        default: begin
          buffer_enable    <= 1'b0; // [R1]
          reference_enable <= 1'b0;
        end
      endcase
    end
  end

  // Start edge: sample pulse and result capture
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_r     <= 16'h0000;
      cnt_r        <= 16'h0000;
      self_r       <= 1'b0;
      sample_hold  <= 1'b0;
      convert_done <= 1'b0;
    end else begin
      sample_hold  <= cnv_rise; // [R5]
      convert_done <= cnv_rise;
      if (cnv_rise) begin
        result_r <= analog_code;
        cnt_r    <= cnt_r + 16'd1;
        // Mode strap read afresh at every start
        self_r   <= ~strap_lvl_r; // [R8]
      end
    end
  end

  // Spacing watchdog; the first conversion is never stale
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_r      <= 14'h0000;
      gap_seen_r <= 1'b0;
      stale_r    <= 1'b0;
    end else begin
      if (cnv_rise) begin
        // Result after an overlong gap is flagged, not dropped
        stale_r    <= gap_seen_r & gap_full; // [R13]
        gap_r      <= 14'h0000;
        gap_seen_r <= 1'b1;
      end else if (!gap_full) begin
        gap_r <= gap_r + 14'd1;
      end
    end
  end

  // Shift path next state; a new start restarts any frame
  always @* begin
    state_nxt = state_r;
    shreg_nxt = shreg_r;
    left_nxt  = left_r;
    data_nxt  = serial_data_out;

    if (cnv_rise) begin
      state_nxt = ST_SHIFT;
      if (!strap_lvl_r) begin
        shreg_nxt = {HDR, analog_code}; // [R9] [R16]
        left_nxt  = `ASRC_DATA_BITS + `ASRC_HDR_BITS;
        data_nxt  = HDR[1]; // [R9]
      end else begin
        shreg_nxt = {analog_code, 2'b00}; // [R16]
        left_nxt  = `ASRC_DATA_BITS;
        data_nxt  = analog_code[15]; // [R7]
      end
    end else begin
      case (state_r)
        ST_SHIFT: begin
          if (sclk_fall) begin
            // Next bit moves out on each falling shift edge
            shreg_nxt = {shreg_r[16:0], 1'b0}; // [R12] [R11]
            data_nxt  = shreg_r[16]; // [R7]
            left_nxt  = left_r - 5'd1;
            if (left_r == 5'd1)
              state_nxt = ST_IDLE;
          end
        end
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  // Shift path flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r         <= ST_IDLE;
      shreg_r         <= 18'h00000;
      left_r          <= 5'd0;
      serial_data_out <= 1'b0;
      echo_clock_out  <= 1'b0;
    end else begin
      state_r         <= state_nxt;
      shreg_r         <= shreg_nxt;
      left_r          <= left_nxt;
      serial_data_out <= data_nxt;
      // Echo is a replica only in echoed-clock mode
      echo_clock_out  <= echo_nxt; // [R10] [R8] [R11]
    end
  end

  // APB slave, zero wait states, error on unmapped address
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r  <= `ASRC_CTRL_RST;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_setup;
      pslverr <= 1'b0;
      if (apb_setup) begin
        prdata <= 32'h0000_0000;
        case (paddr)
          `ASRC_CTRL_OFF:   prdata <= ctrl_r;
          `ASRC_STAT_OFF: begin
            prdata[`ASRC_STAT_SELF]    <= self_r;
            prdata[`ASRC_STAT_ILLEGAL] <= (sel == 2'b00);
            prdata[`ASRC_STAT_BUF_ON]  <= buffer_enable;
            prdata[`ASRC_STAT_REF_ON]  <= reference_enable;
            prdata[`ASRC_STAT_BUSY]    <= (state_r == ST_SHIFT);
            prdata[`ASRC_STAT_STALE]   <= stale_r;
            prdata[`ASRC_STAT_CMOS]    <= cmos_r;
          end
          `ASRC_SAMPLE_OFF: prdata <= {16'h0000, analog_code};
          `ASRC_RESULT_OFF: prdata <= {16'h0000, result_r};
          `ASRC_COUNT_OFF:  prdata <= {16'h0000, cnt_r};
          default:          pslverr <= 1'b1;
        endcase
      end
      if (apb_wr && paddr == `ASRC_CTRL_OFF)
        ctrl_r <= {30'h0, pwdata[1:0]};
    end
  end

endmodule

// File: rtl/asrc_regs.vh
/*
 Constants for the serial readout control block: register offsets,
 field positions, reset values and timing counts.
 Assumes inclusion by bare name from the design file.
*/
`ifndef ASRC_REGS_VH
`define ASRC_REGS_VH

// Register byte offsets on APB
`define ASRC_CTRL_OFF      12'h000
`define ASRC_STAT_OFF      12'h004
`define ASRC_SAMPLE_OFF    12'h008
`define ASRC_RESULT_OFF    12'h00c
`define ASRC_COUNT_OFF     12'h010

// Control fields
`define ASRC_CTRL_SEL_LO   0
`define ASRC_CTRL_SEL_HI   1
`define ASRC_CTRL_RST      32'h0000_0003

// Status fields
`define ASRC_STAT_SELF     0
`define ASRC_STAT_ILLEGAL  1
`define ASRC_STAT_BUF_ON   2
`define ASRC_STAT_REF_ON   3
`define ASRC_STAT_BUSY     4
`define ASRC_STAT_STALE    5
`define ASRC_STAT_CMOS     6

// Frame geometry
`define ASRC_DATA_BITS     5'd16
`define ASRC_HDR_BITS      5'd2
`define ASRC_HEADER        2'b10

// Longest spacing between conversions, ns, and its cycle count
`define ASRC_MAX_GAP_NS    10000
`define ASRC_CLK_NS        10
`define ASRC_MAX_GAP_CYC   (`ASRC_MAX_GAP_NS / `ASRC_CLK_NS)

`endif

// File: tb/asrc_host.sv
/* Host model: start pulse, then a burst clock of 125 ns period.
   Assumes each bit settles within 60 ns of a falling edge. */
`timescale 1ns/1ps
module asrc_host (
  output reg        convert_start_pos,
  output reg        shift_clk_pos,
  input  wire       serial_data_out,
  output reg [17:0] word
);
  initial begin
    convert_start_pos = 1'b0;
    shift_clk_pos = 1'b0;
    word = 18'h0;
  end
  // Clock idles low outside the burst
  task read(input integer n);
    integer i;
    begin
      #3 convert_start_pos = 1'b1;
      #40 convert_start_pos = 1'b0;
      #110;
      for (i = 0; i < n; i = i + 1) begin
        #62.5 shift_clk_pos = 1'b1;
        word = {word[16:0], serial_data_out};
        #62.5 shift_clk_pos = 1'b0;
      end
    end
  endtask
endmodule

// File: tb/asrc_readout_asserts.sv
/* Pin checker for asrc_readout, bound at the foot of this file.
   Assumes strap and code are held steady around each start. */
`timescale 1ns/1ps
module asrc_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        convert_start_pos,
  input wire        shift_clk_pos,
  input wire        echo_clock_strap,
  input wire [15:0] analog_code,
  input wire        serial_data_out,
  input wire        echo_clock_out,
  input wire        ref_select_low,
  input wire        ref_select_high,
  input wire        buffer_enable,
  input wire        reference_enable,
  input wire        sample_hold,
  input wire        convert_done
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire [1:0] sel = {ref_select_high, ref_select_low};
  // Two samples, since reset loads selects 11 while the decode is off
  AST_SEL_01: assert property ((sel == 2'b01)[*2] |->
    buffer_enable && !reference_enable) else $error("sel 01");
  AST_SEL_10: assert property ((sel == 2'b10)[*2] |->
    !buffer_enable && !reference_enable) else $error("sel 10");
  AST_SEL_11: assert property ((sel == 2'b11)[*2] |->
    buffer_enable && reference_enable) else $error("sel 11");
  AST_START: assert property ($rose(convert_start_pos) |->
    ##[1:6] sample_hold && convert_done) else $error("no start");
  AST_HDR: assert property (sample_hold && !echo_clock_strap |->
    ##[0:1] serial_data_out) else $error("no header");
  AST_MSB: assert property (sample_hold && echo_clock_strap |->
    ##[0:1] serial_data_out == analog_code[15]) else $error("msb");
  AST_ECHO: assert property ($rose(shift_clk_pos) && echo_clock_strap
    |-> ##[1:6] echo_clock_out) else $error("no echo");
  AST_HOLD: assert property (shift_clk_pos[*6] |->
    $stable(serial_data_out)) else $error("data moved");
  AST_ECHO_OFF: assert property (sample_hold && !echo_clock_strap |->
    !echo_clock_out) else $error("echo in self mode");
endmodule
bind asrc_readout asrc_chk asrc_chk_i (.*);

// File: tb/testbench.sv
/* Bench top: APB master, host model and design.
   Assumes the checker binds itself to the design. */
`timescale 1ns/1ps
`include "asrc_regs.vh"
module testbench;
  reg         pclk, presetn, psel, penable, pwrite, e;
  reg         convert_start_neg, echo_clock_strap;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, q;
  reg  [15:0] analog_code;
  wire [31:0] prdata;
  wire [17:0] word;
  wire        pready, pslverr, convert_start_pos, shift_clk_pos;
  wire        serial_data_out, echo_clock_out, ref_select_low;
  wire        ref_select_high, buffer_enable, reference_enable;
  wire        sample_hold, convert_done;
  integer     mismatches, total_checks;
  wire [31:0] refpins = {28'h0, ref_select_high, ref_select_low,
                         reference_enable, buffer_enable};
  asrc_readout asrc_readout_i (.*);
  asrc_host    asrc_host_i (.*);
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("wrong value at %0t: %h vs %h", $time, got, exp);
      end
    end
  endtask
  // Request held until pready; no latency assumed
  task apb(input [11:0] a, input w, input [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
        n = n + 1;
        @(posedge pclk);
      end
      q = prdata;
      e = pslverr;
      if (n == 20) mismatches = mismatches + 1;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // Select write, then two edges for the registered pins to follow
  task t_sel(input [31:0] d);
    begin
      apb(`ASRC_CTRL_OFF, 1'b1, d);
      repeat (2) @(posedge pclk);
    end
  endtask
  task t_ref;
    begin
      apb(`ASRC_CTRL_OFF, 1'b0, 32'h0);
      chk(q, 32'h3);
      t_sel(32'h1);
      chk(refpins, 32'h5);
      t_sel(32'h2);
      chk(refpins, 32'h8);
      t_sel(32'h3);
      chk(refpins, 32'hf);
      apb(`ASRC_STAT_OFF, 1'b0, 32'h0);
      chk(q & 32'h7c, 32'h4c);
      apb(12'hffc, 1'b0, 32'h0);
      chk({31'h0, e}, 32'h1);
      chk(q, 32'h0);
    end
  endtask
  task t_frame(input s, input [15:0] c, input integer n, input st);
    begin
      @(posedge pclk);
      echo_clock_strap <= s;
      analog_code <= c;
      @(posedge pclk);
      asrc_host_i.read(n);
      chk({16'h0, word[15:0]}, {16'h0, c});
      if (n == 18) chk({30'h0, word[17:16]}, 32'h2);
      apb(`ASRC_RESULT_OFF, 1'b0, 32'h0);
      chk(q, {16'h0, c});
      apb(`ASRC_STAT_OFF, 1'b0, 32'h0);
      chk(q & 32'h31, {26'h0, st, 4'h0, ~s});
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    #400000;
    mismatches = mismatches + 1;
    wrap_up;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
    {convert_start_neg, echo_clock_strap, analog_code} = 0;
    {mismatches, total_checks} = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_ref;
    t_frame(1'b0, 16'hb4c3, 18, 1'b0);
    t_frame(1'b1, 16'h5a3c, 16, 1'b0);
    // Idle past the longest spacing: next result must be flagged
    repeat (1100) @(posedge pclk);
    t_frame(1'b1, 16'h8001, 16, 1'b1);
    apb(`ASRC_COUNT_OFF, 1'b0, 32'h0);
    chk(q, 32'h3);
    wrap_up;
  end
endmodule
